// file: design/isp_pkg.sv
// Constants, types and instruction codes shared by the serial programming loader.
package isp_pkg;

	// System clock period and self-timed write delays.
	localparam real CLK_PERIOD_NS = 5.0;
	localparam real FLASH_WAIT_MS = 14.0;
	localparam real EEPROM_WAIT_MS = 3.4;
	localparam real ERASE_WAIT_MS = 28.0;
	localparam int FLASH_WAIT_CYC = int'($ceil(FLASH_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int EEPROM_WAIT_CYC = int'($ceil(EEPROM_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));
	localparam int ERASE_WAIT_CYC = int'($ceil(ERASE_WAIT_MS * 1.0e6 / CLK_PERIOD_NS));

	// Array geometry.
	localparam int FLASH_BYTES = 16384;
	localparam int EE_BYTES = 512;
	localparam int PAGE_BYTES = 128;
	localparam logic [13:0] FLASH_LAST = 14'h3fff;
	localparam logic [6:0] PAGE_LAST = 7'h7f;
	localparam logic [7:0] ERASED = 8'hff;

	// Instruction codes and field positions.
	localparam logic [7:0] OPC_PE1 = 8'hac;
	localparam logic [7:0] OPC_PE2 = 8'h53;
	localparam logic [2:0] ERASE_SEL = 3'b100;
	localparam logic [7:0] OPC_FL_RD = 8'h20;
	localparam logic [7:0] OPC_LOAD = 8'h40;
	localparam logic [7:0] OPC_PAGE_WR = 8'h4c;
	localparam logic [7:0] OPC_EE_RD = 8'ha0;
	localparam logic [7:0] OPC_EE_WR = 8'hc0;
	localparam logic [7:0] HBIT_MASK = 8'hf7;
	localparam int H_BIT = 3;
	localparam logic [4:0] BYTE3_DONE = 5'd23;
	localparam logic [4:0] WORD_DONE = 5'd31;

	// Controller states.
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_ERASE = 4'b0010,
		ST_COPY = 4'b0100,
		ST_WAIT = 4'b1000
	} isp_state_t;

	// Kind of self-timed operation in progress.
	typedef enum logic [1:0] {BK_NONE, BK_FLASH, BK_EE, BK_ERASE} isp_busy_t;

	// Memory port operations.
	typedef enum logic [2:0] {
		MEM_NOP, MEM_BUF_WR, MEM_PAGE_COPY, MEM_ERASE, MEM_EE_WR, MEM_FL_RD, MEM_EE_RD
	} isp_mem_op_t;

endpackage : isp_pkg

// file: design/isp_mem_if.sv
// Memory port carried between the loader controller and its arrays.
`timescale 1ns/100ps
interface isp_mem_if;
	import isp_pkg::*;
	isp_mem_op_t op;
	logic [13:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;

	// Controller drives requests and takes read data.
	modport ctl (output op, output addr, output wdata, input rdata);
	// Arrays take requests and return registered read data.
	modport mem (input op, input addr, input wdata, output rdata);
endinterface : isp_mem_if

// file: design/isp_mem.sv
// Flash array, EEPROM array and Flash page buffer with a registered read port.
`timescale 1ns/100ps
module isp_mem (
	input wire logic mclk, // System clock.
	isp_mem_if.mem port // Request and read data.
);
	import isp_pkg::*;

	logic [7:0] flash [FLASH_BYTES];
	logic [7:0] eeprom [EE_BYTES];
	logic [7:0] pbuf [PAGE_BYTES];
	logic [7:0] rdata;

	////////////////////////////////////////////////////////////////////////////
	// One operation per cycle; erase writes ff to all arrays at the swept index.
	always_ff @(posedge mclk)
	begin
		case (port.op)
			MEM_BUF_WR: pbuf[port.addr[6:0]] <= port.wdata;
			MEM_PAGE_COPY: flash[port.addr] <= pbuf[port.addr[6:0]];
			MEM_ERASE:
			begin
				flash[port.addr] <= ERASED;
				eeprom[port.addr[8:0]] <= ERASED;
				pbuf[port.addr[6:0]] <= ERASED;
			end
			MEM_EE_WR: eeprom[port.addr[8:0]] <= port.wdata;
			MEM_FL_RD: rdata <= flash[port.addr];
			MEM_EE_RD: rdata <= eeprom[port.addr[8:0]];
			default: rdata <= rdata;
		endcase
	end

	// Read data holds until the next read request.
	assign port.rdata = rdata;

endmodule : isp_mem

// file: design/isp_loader.sv
// Serial in-system programming port for the Flash and EEPROM arrays.
`timescale 1ns/100ps
module isp_loader #(
	parameter int FLASH_WAIT_CYCLES = isp_pkg::FLASH_WAIT_CYC,
	parameter int EEPROM_WAIT_CYCLES = isp_pkg::EEPROM_WAIT_CYC,
	parameter int ERASE_WAIT_CYCLES = isp_pkg::ERASE_WAIT_CYC
) (
	input wire logic mclk, // System clock, 200 MHz.
	input wire logic rst, // Synchronous reset, active high.
	input wire logic dev_reset_n, // Device reset pin; low selects programming.
	input wire logic sck, // Serial clock from the programmer.
	input wire logic mosi, // Serial data in.
	output logic miso, // Serial data out.
	output logic miso_oe, // High while the device drives serial data out.
	output logic prog_active // High while programming mode is enabled.
);
	import isp_pkg::*;
	// Assertions sample on the system clock and rest during reset.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	// Memory port and the arrays behind it.
	isp_mem_if mem_bus ();
	isp_mem isp_mem_inst (.mclk(mclk), .port(mem_bus));

	// True when an opcode matches with the high/low byte select ignored.
	function automatic logic op_match(input logic [7:0] b1, input logic [7:0] code);
		op_match = (b1 & HBIT_MASK) == code;
	endfunction : op_match
	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisers and serial clock edge detection.
	logic rst_s1, rst_s2, sck_s1, sck_s2, sck_s3, mosi_s1, mosi_s2;
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			rst_s1 <= 1'b1;
			rst_s2 <= 1'b1;
			sck_s1 <= 1'b0;
			sck_s2 <= 1'b0;
			sck_s3 <= 1'b0;
			mosi_s1 <= 1'b0;
			mosi_s2 <= 1'b0;
		end
		else
		begin
			rst_s1 <= dev_reset_n;
			rst_s2 <= rst_s1;
			sck_s1 <= sck;
			sck_s2 <= sck_s1;
			sck_s3 <= sck_s2;
			mosi_s1 <= mosi;
			mosi_s2 <= mosi_s1;
		end
	end
	logic prog, sck_rise, sck_fall;
	// Programming mode follows the low reset pin.
	assign prog = !rst_s2;
	assign sck_rise = sck_s2 && !sck_s3;
	assign sck_fall = !sck_s2 && sck_s3;
	////////////////////////////////////////////////////////////////////////////
	// Serial state and instruction decode.
	logic [31:0] shift_in, next_shift_in;
	logic [4:0] bit_cnt, next_bit_cnt;
	logic [7:0] tx_sh, next_tx_sh, tx_hold, next_tx_hold;
	logic load_pend, next_load_pend, rd_sel, next_rd_sel;
	logic enabled, next_enabled, next_miso, next_miso_oe;
	logic [31:0] rx_word;
	logic [7:0] b1, b2, b3, b4, r1, r2, r3, out_byte;
	logic exec_go, rd_go, rd_is_fl, rd_ff, next_rd_ff;
	logic [13:0] rd_fl_addr;
	logic [8:0] rd_ee_addr;
	// Word as it stands with the bit sampled on this rising edge, MSB first.
	assign rx_word = {shift_in[30:0], mosi_s2};
	assign {b1, b2, b3, b4} = rx_word;
	assign {r1, r2, r3} = rx_word[23:0];
	assign exec_go = prog && sck_rise && bit_cnt == WORD_DONE;
	assign rd_is_fl = op_match(r1, OPC_FL_RD);
	assign rd_go = prog && enabled && sck_rise && bit_cnt == BYTE3_DONE
		&& (rd_is_fl || r1 == OPC_EE_RD);
	// Word address a:b with the high/low select as byte address bit 0.
	assign rd_fl_addr = {r2[4:0], r3, r1[H_BIT]};
	assign rd_ee_addr = {r2[0], r3};
	// Byte sent next: stored data for a read, ff when rd_ff is set, else the byte just received.
	assign out_byte = rd_sel ? (rd_ff ? ERASED : mem_bus.rdata) : tx_hold;
	// Next values of the serial shifter, output and enable flag.
	always_comb
	begin
		next_shift_in = shift_in;
		next_bit_cnt = bit_cnt;
		next_tx_sh = tx_sh;
		next_tx_hold = tx_hold;
		next_load_pend = load_pend;
		next_rd_sel = rd_sel;
		next_enabled = enabled;
		next_miso = miso;
		next_miso_oe = miso_oe;
		if (!prog)
		begin
			// Leaving programming mode clears the session and frees the pin.
			next_bit_cnt = 5'h00;
			next_enabled = 1'b0;
			next_load_pend = 1'b0;
			next_rd_sel = 1'b0;
			next_tx_sh = 8'h00;
			next_miso = 1'b0;
			next_miso_oe = 1'b0;
		end
		else
		begin
			next_miso_oe = 1'b1;
			if (sck_rise)
			begin
				next_shift_in = rx_word;
				next_bit_cnt = 5'(bit_cnt + 5'h01);
				if (bit_cnt[2:0] == 3'h7)
				begin
					// Each completed byte is echoed during the following byte, except that read data follows byte 3 of a read.
					next_load_pend = 1'b1;
					next_tx_hold = rx_word[7:0];
					next_rd_sel = rd_go;
				end
				if (exec_go && b1 == OPC_PE1 && b2 == OPC_PE2)
					next_enabled = 1'b1;
			end
			else if (sck_fall)
			begin
				if (load_pend)
				begin
					next_miso = out_byte[7];
					next_tx_sh = {out_byte[6:0], 1'b0};
					next_load_pend = 1'b0;
				end
				else
				begin
					next_miso = tx_sh[7];
					next_tx_sh = {tx_sh[6:0], 1'b0};
				end
			end
		end
	end
	// Serial registers.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			shift_in <= 32'h0000_0000;
			bit_cnt <= 5'h00;
			tx_sh <= 8'h00;
			tx_hold <= 8'h00;
			load_pend <= 1'b0;
			rd_sel <= 1'b0;
			enabled <= 1'b0;
			miso <= 1'b0;
			miso_oe <= 1'b0;
			prog_active <= 1'b0;
		end
		else
		begin
			shift_in <= next_shift_in;
			bit_cnt <= next_bit_cnt;
			tx_sh <= next_tx_sh;
			tx_hold <= next_tx_hold;
			load_pend <= next_load_pend;
			rd_sel <= next_rd_sel;
			enabled <= next_enabled;
			miso <= next_miso;
			miso_oe <= next_miso_oe;
			prog_active <= next_enabled;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Write, erase and self-timed wait controller.
	isp_state_t state, next_state;
	isp_busy_t busy_kind, next_busy_kind;
	logic [13:0] sweep, next_sweep;
	logic [23:0] wait_cnt, next_wait_cnt;
	logic [6:0] busy_page, next_busy_page;
	logic [8:0] busy_ee, next_busy_ee;
	logic sweeping, hit;
	assign sweeping = state == ST_ERASE || state == ST_COPY;
	// A read of the location being written reads as erased.
	assign hit = busy_kind == BK_ERASE
		|| (busy_kind == BK_FLASH && rd_is_fl && rd_fl_addr[13:7] == busy_page)
		|| (busy_kind == BK_EE && !rd_is_fl && rd_ee_addr == busy_ee);
	// Next controller values and the memory request.
	always_comb
	begin
		next_state = state;
		next_busy_kind = busy_kind;
		next_sweep = sweep;
		next_wait_cnt = wait_cnt;
		next_busy_page = busy_page;
		next_busy_ee = busy_ee;
		next_rd_ff = rd_ff;
		mem_bus.op = MEM_NOP;
		mem_bus.addr = 14'h0000;
		mem_bus.wdata = 8'h00;
		if (rd_go)
			next_rd_ff = sweeping || hit;
		if (rd_go && !sweeping)
		begin
			mem_bus.op = rd_is_fl ? MEM_FL_RD : MEM_EE_RD;
			mem_bus.addr = rd_is_fl ? rd_fl_addr : {5'h00, rd_ee_addr};
		end
		case (state)
			ST_IDLE:
			begin
				if (exec_go && enabled)
				begin
					if (b1 == OPC_PE1 && b2[7:5] == ERASE_SEL)
					begin
						next_state = ST_ERASE;
						next_busy_kind = BK_ERASE;
						next_sweep = 14'h0000;
					end
					else if (op_match(b1, OPC_LOAD))
					begin
						mem_bus.op = MEM_BUF_WR;
						mem_bus.addr = {7'h00, b3[5:0], b1[H_BIT]};
						mem_bus.wdata = b4;
					end
					else if (b1 == OPC_PAGE_WR)
					begin
						next_state = ST_COPY;
						next_busy_kind = BK_FLASH;
						next_busy_page = {b2[4:0], b3[7:6]};
						next_sweep = 14'h0000;
					end
					else if (b1 == OPC_EE_WR)
					begin
						mem_bus.op = MEM_EE_WR;
						mem_bus.addr = {5'h00, b2[0], b3};
						mem_bus.wdata = b4;
						next_state = ST_WAIT;
						next_busy_kind = BK_EE;
						next_busy_ee = {b2[0], b3};
						next_wait_cnt = 24'(EEPROM_WAIT_CYCLES);
					end
				end
			end
			ST_ERASE:
			begin
				mem_bus.op = MEM_ERASE;
				mem_bus.addr = sweep;
				next_sweep = 14'(sweep + 14'h0001);
				if (sweep == FLASH_LAST)
				begin
					next_state = ST_WAIT;
					next_wait_cnt = 24'(ERASE_WAIT_CYCLES);
				end
			end
			ST_COPY:
			begin
				mem_bus.op = MEM_PAGE_COPY;
				mem_bus.addr = {busy_page, sweep[6:0]};
				next_sweep = 14'(sweep + 14'h0001);
				if (sweep[6:0] == PAGE_LAST)
				begin
					next_state = ST_WAIT;
					next_wait_cnt = 24'(FLASH_WAIT_CYCLES);
				end
			end
			ST_WAIT:
			begin
				// Self-timed delay; instructions other than reads are ignored.
				next_wait_cnt = 24'(wait_cnt - 24'h000001);
				if (wait_cnt <= 24'h000001)
				begin
					next_state = ST_IDLE;
					next_busy_kind = BK_NONE;
				end
			end
			default:
			begin
				next_state = ST_IDLE;
				next_busy_kind = BK_NONE;
			end
		endcase
	end
	// Controller registers.
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state <= ST_IDLE;
			busy_kind <= BK_NONE;
			sweep <= 14'h0000;
			wait_cnt <= 24'h000000;
			busy_page <= 7'h00;
			busy_ee <= 9'h000;
			rd_ff <= 1'b0;
		end
		else
		begin
			state <= next_state;
			busy_kind <= next_busy_kind;
			sweep <= next_sweep;
			wait_cnt <= next_wait_cnt;
			busy_page <= next_busy_page;
			busy_ee <= next_busy_ee;
			rd_ff <= next_rd_ff;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Checks on the serial engine and controller.
	AST_IDLE_PIN: assert property (rst_s2 |=> !miso_oe && !enabled)
		else $error("serial port active outside programming mode");
	AST_ENABLE_GATE: assert property (
		exec_go && !enabled && state == ST_IDLE |=> state == ST_IDLE)
		else $error("operation accepted before programming enable");
	AST_ERASE_SWEEP: assert property (
		state == ST_ERASE |-> mem_bus.op == MEM_ERASE && mem_bus.addr == sweep)
		else $error("erase sweep lost its memory request");
	AST_EE_WRITE: assert property (
		exec_go && enabled && state == ST_IDLE && b1 == OPC_EE_WR
		|=> state == ST_WAIT && busy_kind == BK_EE && busy_ee == $past(rx_word[16:8]))
		else $error("eeprom write not started");
	AST_RISE_COUNT: assert property (
		prog && sck_rise |=> bit_cnt == 5'($past(bit_cnt) + 5'h01))
		else $error("bit counter missed a rising edge");
	AST_MISO_FALL: assert property (
		$changed(miso) |-> $past(sck_fall) || $past(rst_s2))
		else $error("serial output changed away from a falling edge");
	AST_PAGE_COPY: assert property (
		exec_go && enabled && state == ST_IDLE && b1 == OPC_PAGE_WR
		|=> state == ST_COPY ##128 state == ST_WAIT)
		else $error("page commit did not copy 128 bytes");
	AST_READ_BUSY: assert property (
		rd_go && (sweeping || hit) |=> rd_ff)
		else $error("read of location being written not forced to ff");
	AST_ECHO: assert property (
		prog && sck_fall && load_pend && !rd_sel |=> miso == $past(tx_hold[7]))
		else $error("received byte not echoed");
	AST_READ_DATA: assert property (
		prog && sck_fall && load_pend && rd_sel && !rd_ff
		|=> miso == $past(mem_bus.rdata[7]))
		else $error("read data not sent");
endmodule : isp_loader

// file: sim/isp_prog_model.sv
// Programmer model that drives the serial link and the device reset pin.
`timescale 1ns/100ps
module isp_prog_model (
	input wire logic mclk, // System clock, times the reset pin changes.
	input wire logic miso, // Serial data from the device.
	output logic dev_reset_n, // Device reset pin.
	output logic sck, // Serial clock, 48 ns period, still between frames.
	output logic mosi // Serial data to the device.
);
	int miso_moves; // Serial output changes seen while the clock was high.

	////////////////////////////////////////////////////////////////////////
	// Power-up holds the reset pin and the serial clock low.
	initial
	begin
		dev_reset_n = 1'b0;
		sck = 1'b0;
		mosi = 1'b0;
		miso_moves = 0;
	end

	////////////////////////////////////////////////////////////////////////
	// Moves the reset pin after a clock edge; a pulse lasts far beyond two clocks.
	task automatic set_pin(input logic level);
		@(posedge mclk);
		#1 dev_reset_n = level;
		repeat (8) @(posedge mclk); // Shortened power-up wait keeps the run brief.
	endtask : set_pin

	// Shifts one whole instruction and returns the bytes seen in slots three and four.
	task automatic xfer(input logic [31:0] word, output logic [7:0] rx3, output logic [7:0] rx4);
		logic [31:0] rx;
		logic seen;
		rx = '0;
		for (int i = 31; i >= 0; i--)
		begin
			mosi = word[i];
			#24 sck = 1'b1;
			rx[i] = miso;
			seen = miso;
			#23 if (miso !== seen) miso_moves++;
			#1 sck = 1'b0;
		end
		#24 mosi = ~mosi; // A released line shows no stale bit.
		rx3 = rx[15:8];
		rx4 = rx[7:0];
	endtask : xfer
endmodule : isp_prog_model

// file: sim/isp_loader_tb_top.sv
// Self-checking testbench for the serial programming loader.
`timescale 1ns/100ps
module isp_loader_tb_top;
	import isp_pkg::*;
	localparam int FLASH_CYC = 1200;
	localparam int EE_CYC = 800;
	localparam int ERASE_CYC = 300;
	localparam int TIMEOUT_CYC = 60000;
	logic mclk, rst, dev_reset_n, sck, mosi, miso, miso_oe, prog_active;
	logic [7:0] r3, r4;
	int fail_count, tests_run, cyc;

	isp_loader #(.FLASH_WAIT_CYCLES(FLASH_CYC), .EEPROM_WAIT_CYCLES(EE_CYC),
		.ERASE_WAIT_CYCLES(ERASE_CYC)) isp_loader_inst (.mclk(mclk), .rst(rst),
		.dev_reset_n(dev_reset_n), .sck(sck), .mosi(mosi), .miso(miso),
		.miso_oe(miso_oe), .prog_active(prog_active));
	isp_prog_model isp_prog_model_inst (.mclk(mclk), .miso(miso),
		.dev_reset_n(dev_reset_n), .sck(sck), .mosi(mosi));

	////////////////////////////////////////////////////////////////////////
	// Clock, reset and the hang guard.
	initial
	begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		cyc <= cyc + 1;
		if (cyc == TIMEOUT_CYC)
		begin
			fail_count++;
			print_verdict();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Comparison, verdict and instruction helpers.
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
		begin
			$display("TEST PASSED");
		end
		else
		begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : print_verdict

	task automatic cmd(input logic [31:0] w);
		isp_prog_model_inst.xfer(w, r3, r4);
	endtask : cmd

	// Reads a Flash byte by word address and half, or an EEPROM byte.
	task automatic rd_fl(input logic [12:0] a, input logic h, output logic [7:0] d);
		cmd({4'h2, h, 3'b000, 3'b000, a[12:8], a[7:0], 8'h00});
		d = r4;
	endtask : rd_fl

	task automatic rd_ee(input logic [8:0] a, output logic [7:0] d);
		cmd({8'ha0, 7'h00, a[8], a[7:0], 8'h00});
		d = r4;
	endtask : rd_ee

	////////////////////////////////////////////////////////////////////////
	// Scenarios.
	task automatic s_pin_high();
		isp_prog_model_inst.set_pin(1'b1);
		cmd(32'hac53_0000);
		repeat (4) @(posedge mclk);
		check("active_pin_high", {7'h0, prog_active}, 8'h00);
		check("oe_pin_high", {7'h0, miso_oe}, 8'h00);
	endtask : s_pin_high

	task automatic s_enable();
		isp_prog_model_inst.set_pin(1'b0);
		check("oe_pin_low", {7'h0, miso_oe}, 8'h01);
		cmd(32'hac53_0000);
		check("echo", r3, 8'h53);
		repeat (4) @(posedge mclk);
		check("active", {7'h0, prog_active}, 8'h01);
	endtask : s_enable

	task automatic s_erase();
		logic [7:0] d;
		cmd(32'hac80_0000);
		repeat (16384 + ERASE_CYC + 20) @(posedge mclk);
		rd_fl(13'h1fff, 1'b1, d);
		check("erase_fl", d, 8'hff);
		rd_ee(9'h1ff, d);
		check("erase_ee_top", d, 8'hff);
		rd_ee(9'h000, d);
		check("erase_ee_0", d, 8'hff);
		isp_prog_model_inst.set_pin(1'b1);
		check("leave_active", {7'h0, prog_active}, 8'h00);
		check("leave_oe", {7'h0, miso_oe}, 8'h00);
		isp_prog_model_inst.set_pin(1'b0);
	endtask : s_erase

	task automatic s_refuse();
		logic [7:0] d;
		cmd(32'hc000_0011);
		check("not_enabled", {7'h0, prog_active}, 8'h00);
		cmd(32'hac53_0000);
		repeat (EE_CYC) @(posedge mclk);
		rd_ee(9'h000, d);
		check("refused_write", d, 8'hff);
	endtask : s_refuse

	task automatic s_eeprom();
		logic [7:0] d;
		cmd(32'hc001_ff5a);
		rd_ee(9'h1ff, d);
		check("ee_poll", d, 8'hff);
		repeat (EE_CYC) @(posedge mclk); // Minimum wait after a byte write.
		rd_ee(9'h1ff, d);
		check("ee_data", d, 8'h5a);
		cmd(32'hc001_ffa5);
		repeat (EE_CYC) @(posedge mclk); // Minimum wait after a byte write.
		rd_ee(9'h1ff, d);
		check("ee_rewrite", d, 8'ha5);
		rd_ee(9'h000, d);
		check("ee_other", d, 8'hff);
	endtask : s_eeprom

	task automatic s_flash();
		logic [7:0] d;
		cmd({8'h48, 8'h00, 8'h3f, 8'h3c});
		cmd({8'h40, 8'h00, 8'h00, 8'hc3});
		cmd({8'h4c, 8'h1f, 8'hc0, 8'h00});
		rd_fl(13'h1fff, 1'b1, d);
		check("fl_poll", d, 8'hff);
		repeat (FLASH_CYC) @(posedge mclk); // Polled ff proves nothing.
		rd_fl(13'h1fff, 1'b1, d);
		check("fl_high", d, 8'h3c);
		rd_fl(13'h1fc0, 1'b0, d);
		check("fl_low", d, 8'hc3);
		rd_ee(9'h1ff, d);
		check("spaces_apart", d, 8'ha5);
	endtask : s_flash

	////////////////////////////////////////////////////////////////////////
	// Main sequence.
	initial
	begin
		rst = 1'b1;
		fail_count = 0;
		tests_run = 0;
		cyc = 0;
		repeat (3) @(posedge mclk);
		#1 rst = 1'b0;
		s_pin_high();
		s_enable();
		s_erase();
		s_refuse();
		s_eeprom();
		s_flash();
		isp_prog_model_inst.set_pin(1'b1);
		check("end_oe", {7'h0, miso_oe}, 8'h00);
		check("hold_while_high", {7'h0, isp_prog_model_inst.miso_moves != 0}, 8'h00);
		print_verdict();
	end
endmodule : isp_loader_tb_top
